// >>> rtl/cmp_ctrl_pkg.sv
// constants shared by the comparator control logic
package cmp_ctrl_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] CTRL0_IDX = 8'h9b;
  localparam logic [7:0] MODE0_IDX = 8'h9d;
  localparam logic [7:0] MUX0_IDX = 8'h9f;
  localparam logic [7:0] CTRL1_IDX = 8'ha0;
  localparam logic [7:0] MODE1_IDX = 8'ha1;
  localparam logic [7:0] MUX1_IDX = 8'ha2;
  localparam int ADDR_LSB = 2;
  // control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYP_LSB = 2;
  localparam int CTRL_HYN_LSB = 0;
  // mode register fields
  localparam int MODE_RISE_MASK_BIT = 5;
  localparam int MODE_FALL_MASK_BIT = 4;
  localparam int MODE_RESP_LSB = 0;
  // input select fields
  localparam int MUX_NEG_LSB = 4;
  localparam int MUX_POS_LSB = 0;
  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [7:0] MUX_RESET = 8'hff;
  // hysteresis codes
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_5MV = 2'h1;
  localparam logic [1:0] HYST_10MV = 2'h2;
  localparam logic [1:0] HYST_20MV = 2'h3;
  // response time codes, fastest first
  localparam logic [1:0] RESP_FASTEST = 2'h0;
  localparam logic [1:0] RESP_SLOWEST = 2'h3;
endpackage

// >>> rtl/comparator_unit.sv
// synchroniser, edge detector and output gating for one comparator
`timescale 1ns/1ps
module comparator_unit (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmp_in,
  input wire logic unit_enable,
  output logic raw_out,
  output logic output_state,
  output logic rise_pulse,
  output logic fall_pulse,
  output logic latched_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic state_q;
  logic agree;

  // raw path has no clock so it works with the clock stopped
  assign raw_out = cmp_in & unit_enable;

  // three stage synchroniser, input gated low while disabled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= cmp_in & unit_enable;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign agree = (s2_q == s3_q);

  // accepted output, changes only when stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= 1'b0;
    end else if (agree) begin
      state_q <= s3_q;
    end
  end

  assign output_state = state_q;
  // compare new sample with previous accepted sample
  assign rise_pulse = agree & s3_q & ~state_q;
  assign fall_pulse = agree & ~s3_q & state_q;

  // clock synchronous latched output
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      latched_out <= 1'b0;
    end else begin
      latched_out <= state_q & unit_enable;
    end
  end
endmodule

// >>> rtl/voltage_comparator_control.sv
// control and status logic for two voltage comparators on classic wishbone
// Summary of operation
// - two independent comparators, each with own settings, flags and outputs.
// - control bit 7 enables comparator when 1, disables when 0.
// - read-only bit 6 shows comparator output, readable any time.
// - rise flag set on each rising output edge, held until written 0.
// - fall flag set on each falling output edge, held until cleared.
// - bits 3-2 pick positive hysteresis off, 5, 10, 20 mV.
// - bits 1-0 pick negative hysteresis off, 5, 10, 20 mV.
// - interrupt possible on rising and on falling output edges.
// - rise interrupt request needs rise mask set and rise flag set.
// - fall interrupt request needs fall mask set and fall flag set.
// - raw output reaches its pin with no clocking at all.
// - latched output synchronised to system clock is also offered.
// - disabled comparator drives its routed outputs low.
// - two-bit fields choose positive and negative input pins.
// - first comparator output is offered as a reset source.
// - mode bits 1-0 select response time, 0 fastest, 3 slowest.
// - mode bit 5 rise mask, bit 4 fall mask, unused bits read 0.
`timescale 1ns/1ps
module voltage_comparator_control #(
  parameter int UNITS = 2,
  parameter int ADDR_W = 10
) (
  input wire logic ref_clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog core side
  input wire logic [UNITS-1:0] cmp_in,
  output logic [UNITS-1:0] ana_enable,
  output logic [2*UNITS-1:0] pos_hyst_sel,
  output logic [2*UNITS-1:0] neg_hyst_sel,
  output logic [2*UNITS-1:0] response_time_sel,
  output logic [2*UNITS-1:0] pos_input_sel,
  output logic [2*UNITS-1:0] neg_input_sel,
  // pins and system
  output logic [UNITS-1:0] raw_out,
  output logic [UNITS-1:0] latched_out,
  output logic [UNITS-1:0] rise_irq,
  output logic [UNITS-1:0] fall_irq,
  output logic reset_source
);
  typedef enum {
    REG_NONE,
    REG_CTRL,
    REG_MODE,
    REG_MUX
  } reg_kind_e;

  logic req;
  logic wr_en;
  logic rd_en;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] wbyte;
  logic [7:0] idx;
  logic word_ok;
  reg_kind_e kind;
  logic unit_sel;

  logic [UNITS-1:0] en_q;
  logic [1:0] hyp_q [UNITS];
  logic [1:0] hyn_q [UNITS];
  logic [UNITS-1:0] rise_flag_q;
  logic [UNITS-1:0] fall_flag_q;
  logic [UNITS-1:0] rise_mask_q;
  logic [UNITS-1:0] fall_mask_q;
  logic [1:0] resp_q [UNITS];
  logic [1:0] psel_q [UNITS];
  logic [1:0] nsel_q [UNITS];
  logic [UNITS-1:0] out_state;
  logic [UNITS-1:0] rise_pulse;
  logic [UNITS-1:0] fall_pulse;
  logic [UNITS-1:0] latched;
  logic [7:0] ctrl_rd [UNITS];
  logic [7:0] mode_rd [UNITS];
  logic [7:0] mux_rd [UNITS];

  // index to register kind
  function automatic reg_kind_e kind_of(input logic [7:0] i);
    case (i)
      cmp_ctrl_pkg::CTRL0_IDX,
      cmp_ctrl_pkg::CTRL1_IDX: kind_of = REG_CTRL;
      cmp_ctrl_pkg::MODE0_IDX,
      cmp_ctrl_pkg::MODE1_IDX: kind_of = REG_MODE;
      cmp_ctrl_pkg::MUX0_IDX,
      cmp_ctrl_pkg::MUX1_IDX: kind_of = REG_MUX;
      default: kind_of = REG_NONE;
    endcase
  endfunction

  // index to comparator number
  function automatic logic unit_of(input logic [7:0] i);
    case (i)
      cmp_ctrl_pkg::CTRL1_IDX,
      cmp_ctrl_pkg::MODE1_IDX,
      cmp_ctrl_pkg::MUX1_IDX: unit_of = 1'b1;
      default: unit_of = 1'b0;
    endcase
  endfunction

  // bus decode
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign idx = wb_adr_i[ADDR_W-1:cmp_ctrl_pkg::ADDR_LSB];
  assign word_ok = (wb_adr_i[cmp_ctrl_pkg::ADDR_LSB-1:0] == 2'h0);
  assign kind = word_ok ? kind_of(idx) : REG_NONE;
  assign unit_sel = unit_of(idx);
  // write lands at the edge where the master samples ack high
  assign wr_en = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0] & (kind != REG_NONE);
  assign rd_en = req & ~wb_we_i;
  assign wbyte = wb_dat_i[7:0];

  // one ack per request, dropped the cycle after
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_unit
      logic hit;
      logic ctrl_wr;
      logic mode_wr;
      logic mux_wr;

      assign hit = (int'(unit_sel) == g);
      assign ctrl_wr = wr_en & hit & (kind == REG_CTRL);
      assign mode_wr = wr_en & hit & (kind == REG_MODE);
      assign mux_wr = wr_en & hit & (kind == REG_MUX);

      comparator_unit u_cmp (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cmp_in(cmp_in[g]),
        // gated by the core enable so raw output and core power agree
        .unit_enable(ana_enable[g]),
        .raw_out(raw_out[g]),
        .output_state(out_state[g]),
        .rise_pulse(rise_pulse[g]),
        .fall_pulse(fall_pulse[g]),
        .latched_out(latched[g])
      );

      // enable bit
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          en_q[g] <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::CTRL_EN_BIT];
        end else if (ctrl_wr) begin
          en_q[g] <= wbyte[cmp_ctrl_pkg::CTRL_EN_BIT];
        end
      end

      // hysteresis fields
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          hyp_q[g] <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::CTRL_HYP_LSB +: 2];
          hyn_q[g] <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::CTRL_HYN_LSB +: 2];
        end else if (ctrl_wr) begin
          hyp_q[g] <= wbyte[cmp_ctrl_pkg::CTRL_HYP_LSB +: 2];
          hyn_q[g] <= wbyte[cmp_ctrl_pkg::CTRL_HYN_LSB +: 2];
        end
      end

      // rise flag, edge wins over a software write
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          rise_flag_q[g] <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::CTRL_RISE_BIT];
        end else if (rise_pulse[g]) begin
          rise_flag_q[g] <= 1'b1;
        end else if (ctrl_wr) begin
          rise_flag_q[g] <= wbyte[cmp_ctrl_pkg::CTRL_RISE_BIT];
        end
      end

      // fall flag, edge wins over a software write
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          fall_flag_q[g] <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::CTRL_FALL_BIT];
        end else if (fall_pulse[g]) begin
          fall_flag_q[g] <= 1'b1;
        end else if (ctrl_wr) begin
          fall_flag_q[g] <= wbyte[cmp_ctrl_pkg::CTRL_FALL_BIT];
        end
      end

      // interrupt masks
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          rise_mask_q[g] <= cmp_ctrl_pkg::MODE_RESET[cmp_ctrl_pkg::MODE_RISE_MASK_BIT];
          fall_mask_q[g] <= cmp_ctrl_pkg::MODE_RESET[cmp_ctrl_pkg::MODE_FALL_MASK_BIT];
        end else if (mode_wr) begin
          rise_mask_q[g] <= wbyte[cmp_ctrl_pkg::MODE_RISE_MASK_BIT];
          fall_mask_q[g] <= wbyte[cmp_ctrl_pkg::MODE_FALL_MASK_BIT];
        end
      end

      // response time
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          resp_q[g] <= cmp_ctrl_pkg::MODE_RESET[cmp_ctrl_pkg::MODE_RESP_LSB +: 2];
        end else if (mode_wr) begin
          resp_q[g] <= wbyte[cmp_ctrl_pkg::MODE_RESP_LSB +: 2];
        end
      end

      // input pin selects
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          psel_q[g] <= cmp_ctrl_pkg::MUX_RESET[cmp_ctrl_pkg::MUX_POS_LSB +: 2];
          nsel_q[g] <= cmp_ctrl_pkg::MUX_RESET[cmp_ctrl_pkg::MUX_NEG_LSB +: 2];
        end else if (mux_wr) begin
          psel_q[g] <= wbyte[cmp_ctrl_pkg::MUX_POS_LSB +: 2];
          nsel_q[g] <= wbyte[cmp_ctrl_pkg::MUX_NEG_LSB +: 2];
        end
      end

      // read images
      always_comb begin
        ctrl_rd[g] = 8'h00;
        ctrl_rd[g][cmp_ctrl_pkg::CTRL_EN_BIT] = en_q[g];
        ctrl_rd[g][cmp_ctrl_pkg::CTRL_OUT_BIT] = out_state[g];
        ctrl_rd[g][cmp_ctrl_pkg::CTRL_RISE_BIT] = rise_flag_q[g];
        ctrl_rd[g][cmp_ctrl_pkg::CTRL_FALL_BIT] = fall_flag_q[g];
        ctrl_rd[g][cmp_ctrl_pkg::CTRL_HYP_LSB +: 2] = hyp_q[g];
        ctrl_rd[g][cmp_ctrl_pkg::CTRL_HYN_LSB +: 2] = hyn_q[g];
      end

      always_comb begin
        mode_rd[g] = 8'h00;
        mode_rd[g][cmp_ctrl_pkg::MODE_RISE_MASK_BIT] = rise_mask_q[g];
        mode_rd[g][cmp_ctrl_pkg::MODE_FALL_MASK_BIT] = fall_mask_q[g];
        mode_rd[g][cmp_ctrl_pkg::MODE_RESP_LSB +: 2] = resp_q[g];
      end

      // unused select bits read as one, like their reset value
      always_comb begin
        mux_rd[g] = 8'hff;
        mux_rd[g][cmp_ctrl_pkg::MUX_POS_LSB +: 2] = psel_q[g];
        mux_rd[g][cmp_ctrl_pkg::MUX_NEG_LSB +: 2] = nsel_q[g];
      end

      // masked interrupt requests
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          rise_irq[g] <= 1'b0;
        end else begin
          rise_irq[g] <= rise_mask_q[g] & rise_flag_q[g];
        end
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          fall_irq[g] <= 1'b0;
        end else begin
          fall_irq[g] <= fall_mask_q[g] & fall_flag_q[g];
        end
      end

      // settings to the analog core
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          ana_enable[g] <= 1'b0;
        end else begin
          ana_enable[g] <= en_q[g];
        end
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          pos_hyst_sel[2*g +: 2] <= cmp_ctrl_pkg::HYST_OFF;
          neg_hyst_sel[2*g +: 2] <= cmp_ctrl_pkg::HYST_OFF;
        end else begin
          pos_hyst_sel[2*g +: 2] <= hyp_q[g];
          neg_hyst_sel[2*g +: 2] <= hyn_q[g];
        end
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          response_time_sel[2*g +: 2] <= cmp_ctrl_pkg::MODE_RESET[1:0];
        end else begin
          response_time_sel[2*g +: 2] <= resp_q[g];
        end
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          pos_input_sel[2*g +: 2] <= cmp_ctrl_pkg::MUX_RESET[1:0];
          neg_input_sel[2*g +: 2] <= cmp_ctrl_pkg::MUX_RESET[5:4];
        end else begin
          pos_input_sel[2*g +: 2] <= psel_q[g];
          neg_input_sel[2*g +: 2] <= nsel_q[g];
        end
      end
    end
  endgenerate

  assign latched_out = latched;

  // first comparator offered to the reset logic
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reset_source <= 1'b0;
    end else begin
      reset_source <= latched[0];
    end
  end

  // read data, zero for unmapped or write cycles
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (kind)
        REG_CTRL: rdata_q <= {24'h00_0000, ctrl_rd[unit_sel]};
        REG_MODE: rdata_q <= {24'h00_0000, mode_rd[unit_sel]};
        REG_MUX: rdata_q <= {24'h00_0000, mux_rd[unit_sel]};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
endmodule

// >>> verification/cmp_core_model.sv
// behavioural analog comparator pair seen by the control logic
`timescale 1ns/1ps
module cmp_core_model (
  input wire logic [1:0] ana_enable,
  input wire logic [1:0] level,
  output logic [1:0] cmp_in
);
  // a powered-down comparator settles low
  assign cmp_in = ana_enable & level;
endmodule

// >>> verification/tb_voltage_comparator_control.sv
// self-checking bench for the comparator control logic
`timescale 1ns/1ps
module tb_voltage_comparator_control;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h0;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q, rdat;
  logic ack, reset_source;
  logic [1:0] level = 2'h0;
  logic [1:0] cmp_in, ana_enable, raw_out, latched_out, rise_irq, fall_irq;
  logic [3:0] pos_hyst_sel, neg_hyst_sel, response_time_sel, pos_input_sel, neg_input_sel;
  int fails = 0;
  int check_count = 0;
  always #5 ref_clk = ~ref_clk;
  voltage_comparator_control i_dut (.ref_clk, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(q),
    .wb_ack_o(ack), .cmp_in, .ana_enable, .pos_hyst_sel, .neg_hyst_sel, .response_time_sel,
    .pos_input_sel, .neg_input_sel, .raw_out, .latched_out, .rise_irq, .fall_irq,
    .reset_source);
  cmp_core_model i_core (.ana_enable, .level, .cmp_in);
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      fails++;
      conclude();
    end
    // registered outputs follow the write by one more edge
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rdat, {24'h0, exp});
  endtask
  task automatic wait_lat(input logic v);
    int n;
    n = 0;
    while (latched_out[0] !== v && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20) begin
      fails++;
      conclude();
    end
  endtask
  initial begin
    logic [1:0] p;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    chk(response_time_sel, 4'ha);
    chk(pos_input_sel, 4'hf);
    rd(cmp_ctrl_pkg::CTRL0_IDX, cmp_ctrl_pkg::CTRL_RESET);
    rd(cmp_ctrl_pkg::MODE0_IDX, cmp_ctrl_pkg::MODE_RESET);
    rd(cmp_ctrl_pkg::MUX1_IDX, cmp_ctrl_pkg::MUX_RESET);
    rd(8'h00, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      bus(1'b1, cmp_ctrl_pkg::CTRL0_IDX, {4'h0, p, ~p});
      chk(pos_hyst_sel[1:0], p);
      chk(neg_hyst_sel[1:0], {~p});
      rd(cmp_ctrl_pkg::CTRL0_IDX, {4'h0, p, ~p});
      bus(1'b1, cmp_ctrl_pkg::MODE0_IDX, {6'h0, p});
      chk(response_time_sel[1:0], p);
      bus(1'b1, cmp_ctrl_pkg::CTRL1_IDX, {4'h0, ~p, p});
      chk(pos_hyst_sel[3:2], {~p});
    end
    bus(1'b1, cmp_ctrl_pkg::MODE0_IDX, 8'hff);
    rd(cmp_ctrl_pkg::MODE0_IDX, 8'h33);
    bus(1'b1, cmp_ctrl_pkg::MUX0_IDX, 8'h21);
    chk({neg_input_sel[1:0], pos_input_sel[1:0]}, 4'h9);
    rd(cmp_ctrl_pkg::MUX0_IDX, 8'hed);
    bus(1'b1, 8'h9c, 8'h80);
    chk(ana_enable, 2'h0);
    $display("register test done");
    bus(1'b1, cmp_ctrl_pkg::MODE0_IDX, 8'h00);
    bus(1'b1, cmp_ctrl_pkg::CTRL0_IDX, 8'h00);
    level <= 2'h3;
    repeat (2) @(posedge ref_clk);
    chk(raw_out, 2'h0);
    bus(1'b1, cmp_ctrl_pkg::CTRL0_IDX, 8'h80);
    chk(ana_enable, 2'h1);
    chk(raw_out, 2'h1);
    wait_lat(1'b1);
    rd(cmp_ctrl_pkg::CTRL0_IDX, 8'he0);
    bus(1'b1, cmp_ctrl_pkg::CTRL0_IDX, 8'h80);
    rd(cmp_ctrl_pkg::CTRL0_IDX, 8'hc0);
    bus(1'b1, cmp_ctrl_pkg::MODE0_IDX, 8'h30);
    repeat (2) @(posedge ref_clk);
    chk(rise_irq, 2'h0);
    chk(reset_source, 1'b1);
    level <= 2'h2;
    wait_lat(1'b0);
    rd(cmp_ctrl_pkg::CTRL0_IDX, 8'h90);
    chk(fall_irq, 2'h1);
    level <= 2'h3;
    wait_lat(1'b1);
    repeat (2) @(posedge ref_clk);
    chk(rise_irq, 2'h1);
    rd(cmp_ctrl_pkg::CTRL0_IDX, 8'hf0);
    bus(1'b1, cmp_ctrl_pkg::MODE0_IDX, 8'h10);
    repeat (2) @(posedge ref_clk);
    chk({rise_irq, fall_irq}, 4'h1);
    bus(1'b1, cmp_ctrl_pkg::CTRL0_IDX, 8'h00);
    chk(raw_out, 2'h0);
    repeat (8) @(posedge ref_clk);
    chk(latched_out, 2'h0);
    bus(1'b1, cmp_ctrl_pkg::CTRL1_IDX, 8'h80);
    chk(raw_out, 2'h2);
    $display("comparator test done");
    conclude();
  end
endmodule

// >>> verification/voltage_comparator_control_asserts.sv
// port assertions for the comparator control logic
`timescale 1ns/1ps
module voltage_comparator_control_asserts #(
  parameter int UNITS = 2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [UNITS-1:0] cmp_in,
  input wire logic [UNITS-1:0] ana_enable,
  input wire logic [2*UNITS-1:0] pos_hyst_sel,
  input wire logic [2*UNITS-1:0] neg_hyst_sel,
  input wire logic [2*UNITS-1:0] response_time_sel,
  input wire logic [2*UNITS-1:0] pos_input_sel,
  input wire logic [2*UNITS-1:0] neg_input_sel,
  input wire logic [UNITS-1:0] raw_out,
  input wire logic [UNITS-1:0] latched_out,
  input wire logic [UNITS-1:0] rise_irq,
  input wire logic [UNITS-1:0] fall_irq,
  input wire logic reset_source
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr_ack;
    wb_ack_o && wb_we_i;
  endsequence
  ack_after_req_a: assert property (s_req |=> wb_ack_o) else $error("no ack");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
  data_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
  write_data_zero_a: assert property (s_wr_ack |-> wb_dat_o == 32'h0) else $error("write data");
  enable_by_write_a: assert property ($changed(ana_enable) |-> $past(wb_ack_o && wb_we_i, 2))
    else $error("enable moved");
  settings_by_write_a: assert property ($changed({pos_hyst_sel, neg_hyst_sel,
    response_time_sel, pos_input_sel, neg_input_sel}) |-> $past(wb_ack_o && wb_we_i, 2))
    else $error("setting moved");
  raw_gate_a: assert property (raw_out == (cmp_in & ana_enable)) else $error("raw out");
  off_low_a: assert property (!ana_enable[0] [*3] |-> !latched_out[0])
    else $error("latched while off");
  reset_follow_a: assert property ($rose(latched_out[0]) |=> reset_source)
    else $error("reset source");
  rise_cause_a: assert property ($rose(rise_irq[0]) |->
    $rose(latched_out[0]) || $past(wb_ack_o && wb_we_i, 2)) else $error("rise irq cause");
  fall_cause_a: assert property ((ana_enable[0] [*8]) ##0 $rose(fall_irq[0]) |->
    $fell(latched_out[0]) || $past(wb_ack_o && wb_we_i, 2)) else $error("fall irq cause");
endmodule
bind voltage_comparator_control voltage_comparator_control_asserts #(.UNITS(UNITS)) i_asserts (
  .ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .cmp_in,
  .ana_enable, .pos_hyst_sel, .neg_hyst_sel, .response_time_sel, .pos_input_sel,
  .neg_input_sel, .raw_out, .latched_out, .rise_irq, .fall_irq, .reset_source);
